// *** hw/aoc_correction.sv ***
// Offset and gain correction applied to averaged conversion results.
// Assumes samples arrive one per valid cycle from the averaging stage.
// Assumes select, write strobe and enables are synchronous to mclk_in.
// Assumes rst_b_in may assert at any time; its release is synchronised here.
`timescale 1ns/1ps
`include "aoc_map.svh"
module aoc_correction (
  // Clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        rst_b_in,
  // Averaged sample stream
  input  wire logic                        sample_valid_in,
  input  wire aoc_pkg::aoc_sample_type     sample_in,
  // Correction configuration
  input  wire logic [`AOC_NUM_CH-1:0]      correction_enable_in,
  input  wire logic [`AOC_UNIT_W-1:0]      correction_unit_select_in,
  input  wire logic                        correction_values_wr_in,
  input  wire aoc_pkg::aoc_values_type     correction_values_wdata_in,
  // Readback
  output aoc_pkg::aoc_values_type          correction_values_out,
  // Corrected stream
  output logic                             result_valid_out,
  output aoc_pkg::aoc_sample_type          result_out
);
  import aoc_pkg::*;

  // Fixed sizes
  localparam int NUM_CH  = `AOC_NUM_CH;
  localparam int NUM_U   = `AOC_NUM_UNIT;
  localparam int DATA_W  = `AOC_DATA_W;
  localparam int CORR_W  = `AOC_CORR_W;
  localparam int CH_W    = `AOC_CH_W;
  localparam int UNIT_W  = `AOC_UNIT_W;

  // Derived operand widths
  localparam int SUM_W   = `AOC_DATA_W + 1;
  localparam int GAIN_XW = `AOC_CORR_W + 1;
  localparam int PW      = SUM_W + GAIN_XW;

  // Reset copy
  logic                      rst_meta_r;
  logic                      rst_meta_nxt;
  logic                      rst_sync_r;
  logic                      rst_sync_nxt;

  // Stored pairs and readback
  aoc_values_type            bank_values [NUM_U];
  logic [NUM_U-1:0]          bank_wr;
  aoc_values_type            rd_values_r;
  aoc_values_type            rd_values_nxt;

  // Operand selection
  logic [NUM_CH-1:0]         ch_hit;
  logic                      ch_in_range;
  logic                      apply_corr;
  aoc_values_type            pair;
  logic signed [SUM_W-1:0]   data_ext;
  logic signed [SUM_W-1:0]   offs_ext;
  logic signed [GAIN_XW-1:0] gain_ext;

  // Arithmetic
  logic signed [SUM_W-1:0]   sum;
  logic signed [PW-1:0]      prod;
  logic signed [PW-1:0]      shifted;
  logic [DATA_W-1:0]         corr_data;

  // Result registers
  logic                      result_valid_r;
  logic                      result_valid_nxt;
  aoc_sample_type            result_r;
  aoc_sample_type            result_nxt;

  // Reset release through two flops
  always_comb begin
    rst_meta_nxt = 1'b1;
    rst_sync_nxt = rst_meta_r;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= rst_meta_nxt;
      rst_sync_r <= rst_sync_nxt;
    end
  end

  // Write strobe of each unit
  always_comb begin
    bank_wr = '0;
    for (int u = 0; u < NUM_U; u++) begin
      if (correction_values_wr_in &&
          (correction_unit_select_in == UNIT_W'(u))) begin
        bank_wr[u] = 1'b1;
      end
    end
  end

  // One stored pair per sample-and-hold unit
  for (genvar u = 0; u < NUM_U; u++) begin : g_unit
    aoc_unit_bank u_bank (
      .clk_in     (mclk_in),
      .rst_b_in   (rst_sync_r),
      .wr_in      (bank_wr[u]),
      .wdata_in   (correction_values_wdata_in),
      .values_out (bank_values[u])
    );
  end

  // Readback of the selected unit
  always_comb begin
    rd_values_nxt = rd_values_r;
    case (correction_unit_select_in)
      1'b0: begin
        rd_values_nxt = bank_values[0];
      end
      1'b1: begin
        rd_values_nxt = bank_values[1];
      end
      default: begin
        rd_values_nxt = rd_values_r;
      end
    endcase
  end

  // Readback register
  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rd_values_r <= '0;
    end else begin
      rd_values_r <= rd_values_nxt;
    end
  end

  // Per-channel enable match
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    assign ch_hit[c] = correction_enable_in[c] &&
                       (sample_in.channel == CH_W'(c));
  end

  // Channel codes past the last channel carry no enable
  always_comb begin
    ch_in_range = 1'b0;
    if (sample_in.channel < CH_W'(NUM_CH)) begin
      ch_in_range = 1'b1;
    end
  end

  // Correction applies to valid samples of an enabled channel
  always_comb begin
    apply_corr = 1'b0;
    if (sample_valid_in && ch_in_range && (|ch_hit)) begin
      apply_corr = 1'b1;
    end
  end

  // Pair of the unit that converted the sample
  always_comb begin
    pair = bank_values[0];
    case (sample_in.unit)
      1'b0: begin
        pair = bank_values[0];
      end
      1'b1: begin
        pair = bank_values[1];
      end
      default: begin
        pair = bank_values[0];
      end
    endcase
  end

  // Two's complement operands; gain is unsigned
  always_comb begin
    data_ext = $signed({sample_in.data[DATA_W-1], sample_in.data});
    offs_ext = $signed({pair.offset_correction[CORR_W-1],
                        pair.offset_correction});
    gain_ext = $signed({1'b0, pair.gain_correction});
  end

  // Scaled correction, truncated to the result width
  always_comb begin
    sum       = data_ext + offs_ext;
    prod      = PW'(sum) * PW'(gain_ext);
    shifted   = prod >>> `AOC_GAIN_SHIFT;
    corr_data = shifted[DATA_W-1:0];
  end

  // Valid flag next value
  always_comb begin
    result_valid_nxt = sample_valid_in;
  end

  // Valid register
  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= result_valid_nxt;
    end
  end

  // Result data next value
  always_comb begin
    result_nxt = result_r;
    if (sample_valid_in) begin
      result_nxt.channel = sample_in.channel;
      result_nxt.unit    = sample_in.unit;
      if (apply_corr) begin
        result_nxt.data = corr_data;
      end else begin
        result_nxt.data = sample_in.data;
      end
    end
  end

  // Result register
  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      result_r <= '0;
    end else begin
      result_r <= result_nxt;
    end
  end

  // Outputs come straight from flops
  assign correction_values_out = rd_values_r;
  assign result_valid_out      = result_valid_r;
  assign result_out            = result_r;
endmodule

// *** hw/aoc_unit_bank.sv ***
// Per-unit storage of one offset/gain pair.
// Assumes a synchronised active-low reset and one clock.
`timescale 1ns/1ps
`include "aoc_map.svh"
module aoc_unit_bank (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  // Write port
  input  wire logic                    wr_in,
  input  wire aoc_pkg::aoc_values_type wdata_in,
  // Stored pair
  output aoc_pkg::aoc_values_type      values_out
);
  import aoc_pkg::*;
  aoc_values_type values_r;
  aoc_values_type values_nxt;

  always_comb begin
    values_nxt = values_r;
    if (wr_in) begin
      values_nxt = wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      values_r.offset_correction <= `AOC_OFFS_RST;
      values_r.gain_correction   <= `AOC_GAIN_RST;
    end else begin
      values_r <= values_nxt;
    end
  end

  assign values_out = values_r;
endmodule

// *** shared/aoc_map.svh ***
// Constants for the converter offset/gain correction stage.
// Assumes inclusion by the package and the design files.
// Function
// - Correct only channels whose own correction enable bit is set.
// - Keep one offset and one gain per sample-and-hold unit; use converting unit.
// - Value port shows the pair of the unit chosen by unit select.
// - Unit select steers both value reads and writes; writes touch one pair.
// - Result equals (value plus offset) times gain divided by two to fifteen.
// - Correction follows averaging; data and offset are two's complement, gain is unsigned.
// - Offset is added as a signed quantity.
// - Same computation in every converter operating mode.
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH
`define AOC_NUM_CH      12
`define AOC_NUM_UNIT    2
`define AOC_DATA_W      16
`define AOC_CORR_W      16
`define AOC_CH_W        4
`define AOC_UNIT_W      1
`define AOC_GAIN_SHIFT  15
`define AOC_GAIN_RST    16'h8000
`define AOC_OFFS_RST    16'h0000
`endif

// *** shared/aoc_pkg.sv ***
// Types for the converter offset/gain correction stage.
// Assumes aoc_map.svh is on the include path.
`include "aoc_map.svh"
package aoc_pkg;
  typedef struct packed {
    logic [`AOC_CH_W-1:0]   channel;
    logic [`AOC_UNIT_W-1:0] unit;
    logic [`AOC_DATA_W-1:0] data;
  } aoc_sample_type;
  typedef struct packed {
    logic [`AOC_CORR_W-1:0] offset_correction;
    logic [`AOC_CORR_W-1:0] gain_correction;
  } aoc_values_type;
endpackage

// *** sim/aoc_avg_model.sv ***
// Averaging-stage model: random samples, changing even when not valid.
// Assumes go_in rises once the stage may take samples.
`timescale 1ns/1ps
module aoc_avg_model (
  input  wire logic               mclk_in,
  input  wire logic               go_in,
  output logic                    valid_out = 1'b0,
  output aoc_pkg::aoc_sample_type sample_out = '0
);
  integer      seed = 65;
  logic [31:0] r;
  always @(negedge mclk_in) begin
    r = $random(seed);
    valid_out = go_in && r[31];
    sample_out.data = r[15:0];
    if (r[30:28] == 3'h0) sample_out.data = r[17] ? 16'h8000 : 16'h7FFF;
    sample_out.unit = r[16];
    sample_out.channel = 4'({$random(seed)} % 12);
  end
endmodule

// *** sim/aoc_correction_chk.sv ***
// Checker on the ports of aoc_correction.
// Assumes no request before the reset copy is out.
`timescale 1ns/1ps
module aoc_correction_chk (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic sample_valid_in,
  input wire aoc_pkg::aoc_sample_type sample_in,
  input wire logic [11:0] correction_enable_in,
  input wire logic correction_unit_select_in,
  input wire logic correction_values_wr_in,
  input wire aoc_pkg::aoc_values_type correction_values_wdata_in,
  input wire aoc_pkg::aoc_values_type correction_values_out,
  input wire logic result_valid_out,
  input wire aoc_pkg::aoc_sample_type result_out
);
  import aoc_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_valid_lat: assert property (sample_valid_in |=> result_valid_out)
    else $error("late");
  a_no_spur: assert property (!sample_valid_in |=> !result_valid_out)
    else $error("spur");
  a_hold_out: assert property (!sample_valid_in |=> $stable(result_out))
    else $error("moved");
  a_one_pulse: assert property (result_valid_out |->
    $past(sample_valid_in)) else $error("pulse");
  a_pass_thru: assert property (sample_valid_in &&
    !correction_enable_in[sample_in.channel] |=>
    result_out.data == $past(sample_in.data)) else $error("altered");
  a_unit_copy: assert property (sample_valid_in |=>
    result_out.unit == $past(sample_in.unit)) else $error("unit");
  a_ch_copy: assert property (sample_valid_in |=>
    result_out.channel == $past(sample_in.channel)) else $error("chan");
  a_wr_read: assert property (correction_values_wr_in ##1
    !correction_values_wr_in && $stable(correction_unit_select_in) |=>
    correction_values_out == $past(correction_values_wdata_in, 2))
    else $error("readback");
endmodule
bind aoc_correction aoc_correction_chk u_chk (.*);

// *** sim/aoc_correction_tb.sv ***
// Bench for aoc_correction with a random averaging-stage model.
// Assumes the checker file binds itself to the design.
`timescale 1ns/1ps
module aoc_correction_tb;
  import aoc_pkg::*;
  logic           mclk_in = 1'b0, rst_b_in = 1'b0, go = 1'b0, rv, vin;
  logic           wr = 1'b0, sel = 1'b0;
  logic [11:0]    en = '0;
  aoc_sample_type sin, rout, q[$];
  aoc_values_type wd = '0, vout, p[2] = '{2{32'h8000}};
  integer         seed = 65, n_fail = 0, n_compared = 0;
  initial forever #5 mclk_in = ~mclk_in;
  aoc_avg_model u_src (.mclk_in, .go_in(go), .valid_out(vin),
    .sample_out(sin));
  aoc_correction u_dut (.mclk_in, .rst_b_in, .sample_valid_in(vin),
    .sample_in(sin), .correction_enable_in(en),
    .correction_unit_select_in(sel), .correction_values_wr_in(wr),
    .correction_values_wdata_in(wd), .correction_values_out(vout),
    .result_valid_out(rv), .result_out(rout));
  function automatic aoc_sample_type fx(aoc_sample_type s);
    logic signed [33:0] m;
    m = ($signed(s.data) + $signed(p[s.unit].offset_correction))
      * $signed({1'b0, p[s.unit].gain_correction});
    fx = s;
    if (en[s.channel]) fx.data = m[30:15];
  endfunction
  task cmp_res(aoc_sample_type g, aoc_sample_type e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t result got %h want %h", $time, g, e);
    end
  endtask
  task cmp_val(aoc_values_type g, aoc_values_type e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t values got %h want %h", $time, g, e);
    end
  endtask
  task rd;
    for (int u = 0; u < 2; u++) begin
      @(negedge mclk_in) sel = u[0];
      repeat (2) @(negedge mclk_in);
      cmp_val(vout, p[u]);
    end
    $display("readback test done");
  endtask
  task wrap_up;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    if (vin) q.push_back(fx(sin));
    if (wr) p[sel] = wd;
  end
  always @(negedge mclk_in)
    if (rv === 1'b1) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("mismatch %0t result without sample", $time);
      end else begin
        cmp_res(rout, q.pop_front());
      end
    end
  initial begin
    repeat (3) @(negedge mclk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    rd();
    go = 1'b1;
    repeat (500) @(negedge mclk_in) begin
      en = $random(seed) % 5 ? en : 12'($random(seed));
      sel = 1'($random(seed));
      wr = 1'($random(seed));
      wd = $random(seed) % 7 ? $random(seed) : 32'h8000_FFFF;
    end
    @(negedge mclk_in) wr = 1'b0;
    go = 1'b0;
    $display("stream test done");
    rd();
    if (q.size() != 0) begin
      n_fail++;
      $display("mismatch %0t results missing %0d", $time, q.size());
    end
    wrap_up();
  end
endmodule
